//--- logic/i2c_state_pkg.sv
// package: register map, field positions, state codes, timing counts
package i2c_state_pkg;
    // register byte offsets
    localparam logic [7:0] status_off = 8'h04; // status flags, write one to clear
    localparam logic [7:0] enable_set_off = 8'h08; // interrupt_enable_set
    localparam logic [7:0] enable_clr_off = 8'h0c; // enable clear, write only
    localparam logic [7:0] timeout_off = 8'h10; // time-out limit
    localparam logic [7:0] state_off = 8'h20; // state codes and dma hints
    localparam logic [7:0] control_off = 8'h24; // state-steering control

    // interrupt source bit positions
    localparam int master_pending_bit = 0;
    localparam int master_arb_loss_bit = 4;
    localparam int master_ststp_err_bit = 6;
    localparam int slave_pending_bit = 8;
    localparam int slave_not_str_bit = 11;
    localparam int slave_deselect_bit = 15;
    localparam int monitor_ready_bit = 16;
    localparam int monitor_overrun_bit = 17;
    localparam int monitor_idle_bit = 19;
    localparam int event_timeout_bit = 24;
    localparam int clock_low_timeout_bit = 25;

    // mask of implemented enable bits
    localparam logic [31:0] enable_mask = 32'h030b_8951;
    localparam logic [31:0] enable_reset = 32'h0000_0000;
    localparam logic [15:0] timeout_reset = 16'hffff;

    // state register field positions
    localparam int master_state_lsb = 0;
    localparam int master_dma_bit = 3;
    localparam int slave_state_lsb = 4;
    localparam int slave_dma_bit = 6;
    localparam int slave_selected_bit = 7;

    // control register field positions (write-one actions)
    localparam int slave_continue_pos = 0;
    localparam int slave_refuse_pos = 1;
    localparam int master_continue_pos = 2;

    // master state codes
    typedef enum logic [2:0] {
        master_idle = 3'h0,
        master_rx_ready = 3'h1,
        master_tx_ready = 3'h2,
        master_addr_refused = 3'h3,
        master_data_refused = 3'h4
    } master_state_t;

    // slave state codes
    typedef enum logic [1:0] {
        slave_address_received_state = 2'h0,
        slave_receive_state = 2'h1,
        slave_transmit_state = 2'h2
    } slave_state_t;

    // clock-edge prescale for the time-out counter, one tick per 16 clocks
    localparam int timeout_tick_div = 16;
    localparam logic [3:0] timeout_tick_last = 4'hf;
endpackage

//--- logic/link_sync.sv
// three-stage synchroniser with agreement filter for one link pin
`timescale 1ns/100ps
`default_nettype none
module link_sync (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pin_in,
    input wire logic rst_value,
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1_reg; // first stage, read only by s2
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    wire agree = (s2_reg == s3_reg); // a change counts once stages 2 and 3 agree
    wire level_next = agree ? s3_reg : level_reg;

    // shift chain and filtered level; reset value is constant per instance
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s1_reg <= rst_value;
            s2_reg <= rst_value;
            s3_reg <= rst_value;
            level_reg <= rst_value;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    // edges are derived from the filtered level only
    assign level = level_reg;
    assign rise = level_next & ~level_reg;
    assign fall = ~level_next & level_reg;
endmodule
`default_nettype wire

//--- logic/event_timer.sv
// time-out counter between bus events and for clock-low periods
`timescale 1ns/100ps
`default_nettype none
module event_timer (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic bus_active,
    input wire logic bus_event,
    input wire logic scl_low,
    input wire logic [15:0] limit,
    output logic event_expired,
    output logic low_expired
);
    logic [3:0] pre_reg; // prescaler, one tick per 16 clocks
    logic [15:0] ev_cnt_reg; // ticks since last event
    logic [15:0] low_cnt_reg; // ticks with clock held low
    wire tick = (pre_reg == i2c_state_pkg::timeout_tick_last);
    wire ev_hit = tick & (ev_cnt_reg == limit);
    wire low_hit = tick & (low_cnt_reg == limit);

    // prescaler
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pre_reg <= 4'h0;
        end else begin
            pre_reg <= pre_reg + 4'h1;
        end
    end

    // event spacing counter; idle bus holds it clear so no time-out arises
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !bus_active || bus_event) begin
            ev_cnt_reg <= 16'h0000;
        end else if (tick && ev_cnt_reg != 16'hffff) begin
            ev_cnt_reg <= ev_cnt_reg + 16'h0001;
        end
    end

    // clock-low counter
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !bus_active || !scl_low) begin
            low_cnt_reg <= 16'h0000;
        end else if (tick && low_cnt_reg != 16'hffff) begin
            low_cnt_reg <= low_cnt_reg + 16'h0001;
        end
    end

    // one-cycle pulses when the limit is crossed
    assign event_expired = ev_hit & bus_active & ~bus_event;
    assign low_expired = low_hit & bus_active & scl_low;
endmodule
`default_nettype wire

//--- logic/i2c_state_irq.sv
// state codes, interrupt enables and interrupt request for the i2c block
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module i2c_state_irq (
    input wire logic clk_sys,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // two-wire bus pins, outside the clock domain
    input wire logic scl_in,
    input wire logic sda_in,
    // engine events, same clock domain
    input wire logic master_addr_acked,
    input wire logic master_addr_read,
    input wire logic master_addr_nacked,
    input wire logic master_data_nacked,
    input wire logic master_done,
    input wire logic master_arb_lost,
    input wire logic master_ststp_err,
    input wire logic slave_addr_match,
    input wire logic slave_addr_read,
    input wire logic slave_data_nacked,
    input wire logic slave_not_stretching,
    input wire logic monitor_ready,
    input wire logic monitor_overrun,
    // outputs
    output logic [2:0] master_state_code,
    output logic [1:0] slave_state_code,
    output logic dma_request,
    output logic irq
);
    logic [31:0] enable_reg; // interrupt_enable_set contents
    logic [31:0] flag_reg; // sticky status flags
    logic [15:0] timeout_reg; // time-out limit
    logic [2:0] master_state_reg;
    logic [1:0] slave_state_reg;
    logic master_pend_reg; // master waits for software
    logic slave_pend_reg; // slave waits for software
    logic slave_sel_reg; // slave currently addressed
    logic bus_active_reg; // start seen more recently than stop
    logic [31:0] rdata_reg;
    logic wait_reg; // low only in the answer cycle
    logic irq_reg;
    logic dma_reg;

    // pin synchronisers
    logic scl_lvl, scl_rise, scl_fall;
    logic sda_lvl, sda_rise, sda_fall;
    link_sync scl_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_in(scl_in),
        .rst_value(1'b1),
        .level(scl_lvl),
        .rise(scl_rise),
        .fall(scl_fall)
    );
    link_sync sda_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_in(sda_in),
        .rst_value(1'b1),
        .level(sda_lvl),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    // start and stop are data edges while the clock stays high
    wire bus_start = sda_fall & scl_lvl;
    wire bus_stop = sda_rise & scl_lvl;
    wire bus_event = bus_start | bus_stop | scl_rise | scl_fall;
    wire went_idle = bus_stop & bus_active_reg;
    wire unused_sda = sda_lvl;

    logic ev_expired, low_expired;
    event_timer timer (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .bus_active(bus_active_reg),
        .bus_event(bus_event),
        .scl_low(~scl_lvl),
        .limit(timeout_reg),
        .event_expired(ev_expired),
        .low_expired(low_expired)
    );

    // bus access decode; one wait cycle per access
    wire access = (avs_read | avs_write) & wait_reg;
    wire wr_take = avs_write & ~wait_reg;
    wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wdata = avs_writedata & be_mask;
    wire sel_set = wr_take & (avs_address == i2c_state_pkg::enable_set_off);
    wire sel_clr = wr_take & (avs_address == i2c_state_pkg::enable_clr_off);
    wire sel_sts = wr_take & (avs_address == i2c_state_pkg::status_off);
    wire sel_tmo = wr_take & (avs_address == i2c_state_pkg::timeout_off);
    wire sel_ctl = wr_take & (avs_address == i2c_state_pkg::control_off);
    wire slv_cont = sel_ctl & wdata[i2c_state_pkg::slave_continue_pos];
    wire slv_refuse = sel_ctl & wdata[i2c_state_pkg::slave_refuse_pos];
    wire mst_cont = sel_ctl & wdata[i2c_state_pkg::master_continue_pos];

    // set only, zeros ignored, reserved bits never stored
    wire [31:0] set_bits = sel_set ? (wdata & i2c_state_pkg::enable_mask)
        : 32'h0000_0000;
    wire [31:0] clr_bits = sel_clr ? (wdata & i2c_state_pkg::enable_mask)
        : 32'h0000_0000;
    wire [31:0] enable_next = (enable_reg & ~clr_bits) | set_bits;

    // event sources gathered at their documented bit positions
    logic [31:0] ev_bits;
    always_comb begin
        ev_bits = 32'h0000_0000;
        ev_bits[i2c_state_pkg::master_arb_loss_bit] = master_arb_lost;
        ev_bits[i2c_state_pkg::master_ststp_err_bit] = master_ststp_err;
        ev_bits[i2c_state_pkg::slave_not_str_bit] = slave_not_stretching;
        ev_bits[i2c_state_pkg::slave_deselect_bit] =
            slave_sel_reg & slave_data_nacked;
        ev_bits[i2c_state_pkg::monitor_ready_bit] = monitor_ready;
        ev_bits[i2c_state_pkg::monitor_overrun_bit] = monitor_overrun;
        ev_bits[i2c_state_pkg::monitor_idle_bit] = went_idle;
        ev_bits[i2c_state_pkg::event_timeout_bit] = ev_expired;
        ev_bits[i2c_state_pkg::clock_low_timeout_bit] = low_expired;
    end
    // pending flags are levels, not sticky
    wire [31:0] pend_bits = ({31'h0, master_pend_reg}
        << i2c_state_pkg::master_pending_bit)
        | ({31'h0, slave_pend_reg} << i2c_state_pkg::slave_pending_bit);
    wire [31:0] w1c_bits = sel_sts ? wdata : 32'h0000_0000;
    // set wins over a clear in the same cycle
    wire [31:0] flag_next = ((flag_reg & ~w1c_bits) | ev_bits)
        & i2c_state_pkg::enable_mask;
    wire [31:0] status_view = flag_reg | pend_bits;
    wire irq_next = |(status_view & enable_reg);

    // register storage for enables, flags and limit
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            enable_reg <= i2c_state_pkg::enable_reset;
            flag_reg <= 32'h0000_0000;
            timeout_reg <= i2c_state_pkg::timeout_reset;
        end else begin
            enable_reg <= enable_next;
            flag_reg <= flag_next;
            if (sel_tmo) begin
                timeout_reg <= wdata[15:0];
            end
        end
    end

    // bus activity, tracked from start and stop
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bus_active_reg <= 1'b0;
        end else if (bus_start) begin
            bus_active_reg <= 1'b1;
        end else if (bus_stop) begin
            bus_active_reg <= 1'b0;
        end
    end

    // master state code; the engine drives the transitions
    logic [2:0] master_next;
    always_comb begin
        master_next = master_state_reg;
        if (master_done) begin
            master_next = 3'(i2c_state_pkg::master_idle);
        end else if (master_addr_nacked) begin
            master_next = 3'(i2c_state_pkg::master_addr_refused);
        end else if (master_data_nacked) begin
            master_next = 3'(i2c_state_pkg::master_data_refused);
        end else if (master_addr_acked && master_addr_read) begin
            master_next = 3'(i2c_state_pkg::master_rx_ready);
        end else if (master_addr_acked) begin
            master_next = 3'(i2c_state_pkg::master_tx_ready);
        end
    end
    // pending set by any state-changing master event (not arb loss or st/sp error), dropped when software continues
    wire master_event = master_done | master_addr_nacked
        | master_data_nacked | master_addr_acked;

    // slave state code and selection
    logic [1:0] slave_next;
    always_comb begin
        slave_next = slave_state_reg;
        if (slave_addr_match) begin
            slave_next = 2'(i2c_state_pkg::slave_address_received_state);
        end else if (slv_cont && slave_state_reg ==
                2'(i2c_state_pkg::slave_address_received_state)) begin
            // accepted address picks the data direction
            slave_next = slave_addr_read
                ? 2'(i2c_state_pkg::slave_transmit_state)
                : 2'(i2c_state_pkg::slave_receive_state);
        end
    end
    // refusal by the master in transmit mode ends the selection
    wire slave_drop = slv_refuse | went_idle
        | (slave_data_nacked && slave_state_reg ==
            2'(i2c_state_pkg::slave_transmit_state));
    // continue or refuse both answer the slave's pending request
    wire slave_answer = slv_cont | slv_refuse;

    // state registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            master_state_reg <= 3'(i2c_state_pkg::master_idle);
            slave_state_reg <= 2'(i2c_state_pkg::slave_address_received_state);
            master_pend_reg <= 1'b1;
            slave_pend_reg <= 1'b0;
            slave_sel_reg <= 1'b0;
        end else begin
            master_state_reg <= master_next;
            slave_state_reg <= slave_next;
            // new event wins over a software continue
            master_pend_reg <= master_event | (master_pend_reg & ~mst_cont);
            slave_pend_reg <= slave_addr_match
                | (slave_pend_reg & ~slave_answer & ~slave_drop);
            slave_sel_reg <= slave_addr_match | (slave_sel_reg & ~slave_drop);
        end
    end

    // dma is allowed only in data states
    wire master_dma = (master_state_reg ==
        3'(i2c_state_pkg::master_rx_ready)) | (master_state_reg ==
        3'(i2c_state_pkg::master_tx_ready));
    wire slave_dma = slave_sel_reg & (slave_state_reg !=
        2'(i2c_state_pkg::slave_address_received_state));
    wire dma_next = (master_dma & master_pend_reg)
        | (slave_dma & slave_pend_reg);

    // state view for software
    logic [31:0] state_view;
    always_comb begin
        state_view = 32'h0000_0000;
        state_view[i2c_state_pkg::master_state_lsb +: 3] = master_state_reg;
        state_view[i2c_state_pkg::master_dma_bit] = master_dma;
        state_view[i2c_state_pkg::slave_state_lsb +: 2] = slave_state_reg;
        state_view[i2c_state_pkg::slave_dma_bit] = slave_dma;
        state_view[i2c_state_pkg::slave_selected_bit] = slave_sel_reg;
    end

    // read mux; unmapped and write-only addresses read zero
    wire rd_set = avs_address == i2c_state_pkg::enable_set_off;
    wire rd_sts = avs_address == i2c_state_pkg::status_off;
    wire rd_tmo = avs_address == i2c_state_pkg::timeout_off;
    wire rd_st = avs_address == i2c_state_pkg::state_off;
    wire [31:0] rdata_next = rd_set ? enable_reg
        : rd_sts ? status_view
        : rd_tmo ? {16'h0000, timeout_reg}
        : rd_st ? state_view
        : 32'h0000_0000;

    // bus answer and registered outputs
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
            dma_reg <= 1'b0;
        end else begin
            wait_reg <= ~access;
            if (access && avs_read) begin
                rdata_reg <= rdata_next;
            end
            irq_reg <= irq_next;
            dma_reg <= dma_next;
        end
    end

    // waitrequest is a flop, high whenever no answer is due
    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;
    assign master_state_code = master_state_reg;
    assign slave_state_code = slave_state_reg;
    assign dma_request = dma_reg;
    assign irq = irq_reg;
endmodule
`default_nettype wire

//--- bench/i2c_state_irq_chk.sv
// assertions for the state code and interrupt enable block
`timescale 1ns/100ps
`default_nettype none
module i2c_state_irq_chk (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic master_addr_acked,
    input wire logic master_addr_read,
    input wire logic master_addr_nacked,
    input wire logic master_data_nacked,
    input wire logic master_done,
    input wire logic slave_addr_match,
    input wire logic [2:0] master_state_code,
    input wire logic [1:0] slave_state_code,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire req = avs_read | avs_write; // any bus request
    // a fresh request waits exactly one cycle, then is answered
    sequence s_fresh;
        $rose(req);
    endsequence
    sequence s_answer;
        req && !avs_waitrequest;
    endsequence
    property p_wait_once;
        s_fresh |-> avs_waitrequest ##1 s_answer;
    endproperty
    a_wait_once: assert property (p_wait_once)
        else $error("wrong wait state count");
    // read data may only move while a read is being served
    property p_rdata_hold;
        !$past(sys_rst) && $changed(avs_readdata)
            |-> $past(avs_read && avs_waitrequest);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("stray read data change");
    property p_reset_quiet;
        $fell(sys_rst) |-> !irq && master_state_code == 3'h0
            && slave_state_code == 2'h0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("not clear after reset");
    property p_rx;
        master_addr_acked && master_addr_read |=> master_state_code == 3'h1;
    endproperty
    a_rx: assert property (p_rx)
        else $error("no code 1 after read ack");
    property p_tx;
        master_addr_acked && !master_addr_read |=> master_state_code == 3'h2;
    endproperty
    a_tx: assert property (p_tx)
        else $error("no code 2 after write ack");
    property p_addr_nack;
        master_addr_nacked |=> master_state_code == 3'h3;
    endproperty
    a_addr_nack: assert property (p_addr_nack)
        else $error("no code 3 after addr refusal");
    property p_data_nack;
        master_data_nacked |=> master_state_code == 3'h4;
    endproperty
    a_data_nack: assert property (p_data_nack)
        else $error("no code 4 after data refusal");
    property p_idle;
        master_done |=> master_state_code == 3'h0;
    endproperty
    a_idle: assert property (p_idle)
        else $error("finished master not idle");
    property p_slave_addr;
        slave_addr_match |=> slave_state_code == 2'h0;
    endproperty
    a_slave_addr: assert property (p_slave_addr)
        else $error("no slave code 0 after match");
endmodule
bind i2c_state_irq i2c_state_irq_chk chk (.clk_sys, .sys_rst, .avs_read,
    .avs_write, .avs_waitrequest, .avs_readdata, .master_addr_acked,
    .master_addr_read, .master_addr_nacked, .master_data_nacked,
    .master_done, .slave_addr_match, .master_state_code,
    .slave_state_code, .irq);
`default_nettype wire

//--- bench/bus_partner.sv
// model of another master driving the two-wire bus lines
`timescale 1ns/100ps
`default_nettype none
module bus_partner (
    output logic scl_line,
    output logic sda_line
);
    // lines have pull-ups, so released lines read high
    initial begin
        scl_line = 1'b1;
        sda_line = 1'b1;
    end
    // start: data falls while clock high; offset keeps phase unrelated
    task automatic start_cond;
        #30 sda_line = 1'b0;
        #400;
    endtask
    // clock pulses at 800 ns, data moves in every low phase
    task automatic clocks(input int n);
        repeat (n) begin
            scl_line = 1'b0;
            #200 sda_line = ~sda_line;
            #200 scl_line = 1'b1;
            #400;
        end
    endtask
    // clock held low far longer than the time-out
    task automatic hold_low(input int t);
        scl_line = 1'b0;
        #t scl_line = 1'b1;
        #400;
    endtask
    // stop: data rises while clock high, bus goes idle
    task automatic stop_cond;
        scl_line = 1'b0;
        #200 sda_line = 1'b0;
        #200 scl_line = 1'b1;
        #400 sda_line = 1'b1;
        #400;
    endtask
endmodule
`default_nettype wire

//--- bench/i2c_state_irq_test.sv
// self-checking bench for state codes and interrupt enables
`timescale 1ns/100ps
`default_nettype none
module i2c_state_irq_test;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [4:0] mev = 5'h0; // acked, addr read, addr nack, data nack, done
    logic [4:0] oev = 5'h0; // arb, st/sp err, not str, mon rdy, mon ov
    logic [1:0] sev = 2'h0; // slave addr match, slave data nacked
    logic sdir = 1'b0; // slave direction level
    wire scl_line;
    wire sda_line;
    logic [2:0] mcode;
    logic [1:0] scode;
    logic dma;
    logic irq;
    int miscompares = 0;
    int checks_done = 0;
    always #50 clk_sys = ~clk_sys;
    bus_partner far (.scl_line, .sda_line);
    i2c_state_irq DUT (.clk_sys, .sys_rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
        .avs_waitrequest, .scl_in(scl_line),
        .sda_in(sda_line), .master_addr_acked(mev[0]),
        .master_addr_read(mev[1]), .master_addr_nacked(mev[2]),
        .master_data_nacked(mev[3]), .master_done(mev[4]),
        .master_arb_lost(oev[0]), .master_ststp_err(oev[1]),
        .slave_addr_match(sev[0]), .slave_addr_read(sdir),
        .slave_data_nacked(sev[1]), .slave_not_stretching(oev[2]),
        .monitor_ready(oev[3]), .monitor_overrun(oev[4]),
        .master_state_code(mcode), .slave_state_code(scode),
        .dma_request(dma), .irq);
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // bounded wait for the answer edge; a hang ends the run
    task automatic wait_ack();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            miscompares++;
            tally_and_finish;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
    endtask
    // read, mask and compare in one go
    task automatic rchk(input string nm, input logic [7:0] a,
        input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_sys);
        avs_address <= a;
        avs_read <= 1'b1;
        wait_ack();
        check(nm, avs_readdata & m, e);
        avs_read <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic t_reset;
        check("irq", {31'h0, irq}, 32'h0);
        rchk("enables", 8'h08, 32'h030b_8951, 32'h0);
        rchk("state", 8'h20, 32'hff, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_enables;
        int pos [11] = '{0, 4, 6, 8, 11, 15, 16, 17, 19, 24, 25};
        logic [31:0] acc;
        acc = 32'h0;
        foreach (pos[i]) begin
            wr(8'h08, 32'h1 << pos[i]);
            acc = acc | (32'h1 << pos[i]);
            rchk("enables", 8'h08, 32'h030b_8951, acc);
        end
        wr(8'h08, 32'h0);
        rchk("enables", 8'h08, 32'h030b_8951, acc);
        wr(8'h0c, acc);
        rchk("enables", 8'h08, 32'h030b_8951, 32'h0);
        $display("enable test done");
    endtask
    task automatic t_master;
        logic [4:0] ev [5] = '{5'h03, 5'h01, 5'h04, 5'h08, 5'h10};
        logic [2:0] code [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
        logic ok;
        foreach (ev[i]) begin
            @(posedge clk_sys) mev <= ev[i];
            @(posedge clk_sys) mev <= 5'h0;
            ok = code[i] == 3'h1 || code[i] == 3'h2; // dma only on data
            tick(2);
            check("mcode", {29'h0, mcode}, {29'h0, code[i]});
            check("dma", {31'h0, dma}, {31'h0, ok});
            rchk("state", 8'h20, 32'hf, {28'h0, ok, code[i]});
        end
        // idle master pends; software may mask it
        wr(8'h08, 32'h1);
        tick(2);
        check("irq pending", {31'h0, irq}, 32'h1);
        wr(8'h0c, 32'h1);
        tick(2);
        check("irq masked", {31'h0, irq}, 32'h0);
        $display("master test done");
    endtask
    task automatic spulse(input logic [1:0] v);
        @(posedge clk_sys) sev <= v;
        @(posedge clk_sys) sev <= 2'h0;
        tick(1);
    endtask
    task automatic t_slave;
        spulse(2'h1);
        rchk("slave addr", 8'h20, 32'hf0, 32'h80);
        wr(8'h24, 32'h1);
        rchk("slave rx", 8'h20, 32'hf0, 32'hd0);
        @(posedge clk_sys) sdir <= 1'b1;
        spulse(2'h1);
        wr(8'h24, 32'h1);
        rchk("slave tx", 8'h20, 32'hf0, 32'he0);
        check("slave code", {30'h0, scode}, 32'h2);
        spulse(2'h2);
        rchk("selected", 8'h20, 32'h80, 32'h0);
        rchk("deselect flag", 8'h04, 32'h8000, 32'h8000);
        wr(8'h04, 32'h8000);
        spulse(2'h1);
        wr(8'h24, 32'h2);
        rchk("refused", 8'h20, 32'h80, 32'h0);
        $display("slave test done");
    endtask
    task automatic t_flags;
        int pos [5] = '{4, 6, 11, 16, 17};
        logic [31:0] b;
        foreach (pos[i]) begin
            b = 32'h1 << pos[i];
            @(posedge clk_sys) oev <= 5'h1 << i;
            @(posedge clk_sys) oev <= 5'h0;
            rchk("flag", 8'h04, b, b);
            check("irq off", {31'h0, irq}, 32'h0);
            wr(8'h08, b);
            tick(2);
            check("irq on", {31'h0, irq}, 32'h1);
            wr(8'h04, b);
            tick(2);
            check("irq gone", {31'h0, irq}, 32'h0);
            wr(8'h0c, b);
        end
        $display("flag test done");
    endtask
    // traffic from the far side exercises the time-outs and idle flag
    task automatic t_bus;
        wr(8'h10, 32'h2);
        wr(8'h04, 32'h0308_0000);
        tick(100);
        rchk("idle timeout", 8'h04, 32'h0100_0000, 32'h0);
        far.start_cond;
        far.clocks(9);
        tick(100);
        rchk("event timeout", 8'h04, 32'h0100_0000, 32'h0100_0000);
        far.hold_low(10000);
        rchk("low timeout", 8'h04, 32'h0200_0000, 32'h0200_0000);
        far.stop_cond;
        tick(20);
        rchk("bus idle", 8'h04, 32'h0008_0000, 32'h0008_0000);
        check("idle masked", {31'h0, irq}, 32'h0);
        wr(8'h08, 32'h0008_0000);
        tick(2);
        check("idle irq", {31'h0, irq}, 32'h1);
        wr(8'h04, 32'h0308_0000);
        tick(100);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rchk("no timeout", 8'h04, 32'h0100_0000, 32'h0);
        wr(8'h0c, 32'h0008_0000);
        $display("bus test done");
    endtask
    initial begin
        tick(2);
        sys_rst <= 1'b0;
        tick(1);
        t_reset;
        t_enables;
        t_master;
        t_slave;
        t_flags;
        t_bus;
        tally_and_finish;
    end
endmodule
`default_nettype wire
